// ### hw/sink_regs_pkg.sv
// constants for the sink timing and link status register group
package sink_regs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [11:0] HORIZ_SYNC_TIMING_OFS       = 12'h050;
  localparam logic [11:0] FAST_I2C_CLOCK_PRESCALE_OFS = 12'h060;
  localparam logic [11:0] VIDEO_LOCAL_ID_PRESENT_OFS  = 12'h084;
  localparam logic [11:0] AUDIO_LOCAL_ID_PRESENT_OFS  = 12'h088;
  localparam logic [11:0] REMOTE_MESSAGE_BYTE_OFS     = 12'h08c;
  localparam logic [11:0] SINK_SERVICE_REQUEST_OFS    = 12'h090;
  localparam logic [11:0] VIDEO_NOT_ACCEPTED_OFS      = 12'h094;
  localparam logic [11:0] AUDIO_NOT_ACCEPTED_OFS      = 12'h098;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FRONT_PORCH_LSB    = 8;
  localparam int FRONT_PORCH_MSB    = 15;
  localparam int PULSE_WIDTH_LSB    = 0;
  localparam int PULSE_WIDTH_MSB    = 7;
  localparam int REMOTE_PENDING_BIT = 0;
  localparam int VENDOR_REQ_BIT     = 1;
  localparam int DOWN_REPLY_BIT     = 4;
  localparam int FLAG_BIT           = 0;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [15:0] HORIZ_SYNC_TIMING_RST       = 16'h0f0f;
  localparam logic [31:0] FAST_I2C_CLOCK_PRESCALE_RST = 32'h0000_0000;
  localparam logic [7:0]  REMOTE_MESSAGE_BYTE_RST     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // sync generator states
  typedef enum logic [2:0]
  {
    HS_IDLE  = 3'b001,
    HS_PORCH = 3'b010,
    HS_PULSE = 3'b100
  } hsync_state_t;

endpackage

// ### hw/sticky_request_flag.sv
// one request bit: set by the host, cleared by the far end
`timescale 1ns/1ns
module sticky_request_flag
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic set_req,
  input  wire logic clr_req,
  output logic      flag_r
);

  ////////////////////////////////////////////////////////////////////////////
  // set beats clear so an event in the clearing cycle is not lost
  always_ff @(posedge core_clk)
  begin
    if (rst)
      flag_r <= 1'b0;
    else if (set_req)
      flag_r <= 1'b1;
    else if (clr_req)
      flag_r <= 1'b0;
  end

endmodule

// ### hw/hsync_pulse_gen.sv
// horizontal sync generator: porch delay then fixed-width pulse
`timescale 1ns/1ns
module hsync_pulse_gen
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       line_end,
  input  wire logic [7:0] porch_len,
  input  wire logic [7:0] pulse_len,
  output logic            hsync,
  output logic            busy
);

  sink_regs_pkg::hsync_state_t state_r;
  logic [7:0]                  cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // line ends arriving mid-sequence are ignored; settings latched per phase
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= sink_regs_pkg::HS_IDLE;
      cnt_r   <= 8'h00;
    end
    else
    begin
      unique case (state_r)
        sink_regs_pkg::HS_IDLE:
        begin
          if (line_end)
          begin
            if (porch_len != 8'h00)
            begin
              state_r <= sink_regs_pkg::HS_PORCH; // RULE_02
              cnt_r   <= porch_len;
            end
            else if (pulse_len != 8'h00)
            begin
              state_r <= sink_regs_pkg::HS_PULSE;
              cnt_r   <= pulse_len;
            end
          end
        end
        sink_regs_pkg::HS_PORCH:
        begin
          if (cnt_r == 8'h01)
          begin
            state_r <= (pulse_len != 8'h00) ? sink_regs_pkg::HS_PULSE
                                            : sink_regs_pkg::HS_IDLE;
            cnt_r   <= pulse_len; // RULE_03
          end
          else
            cnt_r <= cnt_r - 8'h01; // RULE_02
        end
        sink_regs_pkg::HS_PULSE:
        begin
          if (cnt_r == 8'h01)
            state_r <= sink_regs_pkg::HS_IDLE;
          else
            cnt_r <= cnt_r - 8'h01; // RULE_03
        end
        default:
        begin
          state_r <= sink_regs_pkg::HS_IDLE;
          cnt_r   <= 8'h00;
        end
      endcase
    end
  end

  // straight from the state flop, active high
  assign hsync = (state_r == sink_regs_pkg::HS_PULSE); // RULE_01
  assign busy  = (state_r != sink_regs_pkg::HS_IDLE);

endmodule

// ### hw/sink_timing_and_link_status_regs.sv
// register group for sync timing, i2c prescale and link status bits
// Function
// [RULE_01] hsync pulse active high, length programmed
// [RULE_02] front porch cycles before hsync rise
// [RULE_03] hsync high exactly pulse-width cycles
// [RULE_04] sync timing register resets to 0x0f0f
// [RULE_05] software sets prescale to clock/10 minus one
// [RULE_06] video local id bit reported to transmitter
// [RULE_07] audio local id bit reported to transmitter
// [RULE_08] eight-bit remote byte offered to transmitter
// [RULE_09] writing one sets remote pending bit
// [RULE_10] writing zero never clears request vector
// [RULE_11] service register reads live vector state
// [RULE_12] bit 1 mirrors vendor local request
// [RULE_13] bit 4 flags down reply ready
// [RULE_14] video not accepted bit reported out
// [RULE_15] audio not accepted bit reported out
// [RULE_16] host reaches registers over apb
// [RULE_17] unused bits read zero, ignore writes
`timescale 1ns/1ns
module sink_timing_and_link_status_regs
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  // apb host port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // video timing side
  input  wire logic        line_end,
  output logic             vid_hsync,
  output logic             hsync_busy,
  // i2c side
  output logic [31:0]      i2c_prescale,
  // link configuration data side
  input  wire logic        remote_pending_clr,
  input  wire logic        down_reply_clr,
  input  wire logic        vendor_local_request,
  output logic             video_local_id_present,
  output logic             audio_local_id_present,
  output logic [7:0]       remote_message_byte,
  output logic             remote_pending,
  output logic             down_reply_ready,
  output logic             video_not_accepted,
  output logic             audio_not_accepted
);

  logic [15:0] horiz_sync_timing_r;
  logic [31:0] fast_i2c_clock_prescale_r;
  logic        video_local_id_r;
  logic        audio_local_id_r;
  logic [7:0]  remote_message_byte_r;
  logic        video_not_accepted_r;
  logic        audio_not_accepted_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic        hit;
  logic        wr_en;
  logic        setup;
  logic [31:0] service_view;
  logic        remote_set;
  logic        down_set;
  logic        sel_timing;
  logic        sel_prescale;
  logic        sel_video_id;
  logic        sel_audio_id;
  logic        sel_remote;
  logic        sel_service;
  logic        sel_video_na;
  logic        sel_audio_na;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, read data captured in setup phase
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & hit; // RULE_16
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_r;

  always_comb
  begin
    unique case (paddr)
      sink_regs_pkg::HORIZ_SYNC_TIMING_OFS,
      sink_regs_pkg::FAST_I2C_CLOCK_PRESCALE_OFS,
      sink_regs_pkg::VIDEO_LOCAL_ID_PRESENT_OFS,
      sink_regs_pkg::AUDIO_LOCAL_ID_PRESENT_OFS,
      sink_regs_pkg::REMOTE_MESSAGE_BYTE_OFS,
      sink_regs_pkg::SINK_SERVICE_REQUEST_OFS,
      sink_regs_pkg::VIDEO_NOT_ACCEPTED_OFS,
      sink_regs_pkg::AUDIO_NOT_ACCEPTED_OFS:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
  end

  // one select per register, exact match only so no aliases appear
  always_comb
  begin
    sel_timing   = (paddr == sink_regs_pkg::HORIZ_SYNC_TIMING_OFS);
    sel_prescale = (paddr == sink_regs_pkg::FAST_I2C_CLOCK_PRESCALE_OFS);
    sel_video_id = (paddr == sink_regs_pkg::VIDEO_LOCAL_ID_PRESENT_OFS);
    sel_audio_id = (paddr == sink_regs_pkg::AUDIO_LOCAL_ID_PRESENT_OFS);
    sel_remote   = (paddr == sink_regs_pkg::REMOTE_MESSAGE_BYTE_OFS);
    sel_service  = (paddr == sink_regs_pkg::SINK_SERVICE_REQUEST_OFS);
    sel_video_na = (paddr == sink_regs_pkg::VIDEO_NOT_ACCEPTED_OFS);
    sel_audio_na = (paddr == sink_regs_pkg::AUDIO_NOT_ACCEPTED_OFS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync timing
  always_ff @(posedge core_clk)
  begin
    if (rst)
      horiz_sync_timing_r <= sink_regs_pkg::HORIZ_SYNC_TIMING_RST; // RULE_04
    else if (wr_en && sel_timing)
      horiz_sync_timing_r <= pwdata[15:0]; // RULE_17
  end

  ////////////////////////////////////////////////////////////////////////////
  // i2c prescale; value is software's job, stored as written
  always_ff @(posedge core_clk)
  begin
    if (rst)
      fast_i2c_clock_prescale_r <= sink_regs_pkg::FAST_I2C_CLOCK_PRESCALE_RST;
    else if (wr_en && sel_prescale)
      fast_i2c_clock_prescale_r <= pwdata; // RULE_05
  end

  assign i2c_prescale = fast_i2c_clock_prescale_r;

  ////////////////////////////////////////////////////////////////////////////
  // capability and status bits for the link configuration data
  always_ff @(posedge core_clk)
  begin
    if (rst)
      video_local_id_r <= 1'b0;
    else if (wr_en && sel_video_id)
      video_local_id_r <= pwdata[sink_regs_pkg::FLAG_BIT]; // RULE_06
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      audio_local_id_r <= 1'b0;
    else if (wr_en && sel_audio_id)
      audio_local_id_r <= pwdata[sink_regs_pkg::FLAG_BIT]; // RULE_07
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      video_not_accepted_r <= 1'b0;
    else if (wr_en && sel_video_na)
      video_not_accepted_r <= pwdata[sink_regs_pkg::FLAG_BIT]; // RULE_14
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      audio_not_accepted_r <= 1'b0;
    else if (wr_en && sel_audio_na)
      audio_not_accepted_r <= pwdata[sink_regs_pkg::FLAG_BIT]; // RULE_15
  end

  assign video_local_id_present = video_local_id_r;
  assign audio_local_id_present = audio_local_id_r;
  assign video_not_accepted     = video_not_accepted_r;
  assign audio_not_accepted     = audio_not_accepted_r;

  ////////////////////////////////////////////////////////////////////////////
  // remote byte
  always_ff @(posedge core_clk)
  begin
    if (rst)
      remote_message_byte_r <= sink_regs_pkg::REMOTE_MESSAGE_BYTE_RST;
    else if (wr_en && sel_remote)
      remote_message_byte_r <= pwdata[7:0]; // RULE_08
  end

  assign remote_message_byte = remote_message_byte_r;

  ////////////////////////////////////////////////////////////////////////////
  // service request vector: host can only set, transmitter clears
  assign remote_set = wr_en && sel_service
                      && pwdata[sink_regs_pkg::REMOTE_PENDING_BIT]; // RULE_09 RULE_10
  assign down_set   = wr_en && sel_service
                      && pwdata[sink_regs_pkg::DOWN_REPLY_BIT]; // RULE_13 RULE_10

  sticky_request_flag u_remote_pending
  (
    .core_clk (core_clk),
    .rst      (rst),
    .set_req  (remote_set),
    .clr_req  (remote_pending_clr),
    .flag_r   (remote_pending)
  );

  sticky_request_flag u_down_reply
  (
    .core_clk (core_clk),
    .rst      (rst),
    .set_req  (down_set),
    .clr_req  (down_reply_clr),
    .flag_r   (down_reply_ready)
  );

  always_comb
  begin
    service_view = 32'h0000_0000;
    service_view[sink_regs_pkg::REMOTE_PENDING_BIT] = remote_pending; // RULE_11
    service_view[sink_regs_pkg::VENDOR_REQ_BIT]     = vendor_local_request; // RULE_12
    service_view[sink_regs_pkg::DOWN_REPLY_BIT]     = down_reply_ready; // RULE_11
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped and unused bits read zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000; // RULE_17
    unique case (paddr)
      sink_regs_pkg::HORIZ_SYNC_TIMING_OFS:
        rd_nxt[15:0] = horiz_sync_timing_r;
      sink_regs_pkg::FAST_I2C_CLOCK_PRESCALE_OFS:
        rd_nxt = fast_i2c_clock_prescale_r;
      sink_regs_pkg::VIDEO_LOCAL_ID_PRESENT_OFS:
        rd_nxt[sink_regs_pkg::FLAG_BIT] = video_local_id_r;
      sink_regs_pkg::AUDIO_LOCAL_ID_PRESENT_OFS:
        rd_nxt[sink_regs_pkg::FLAG_BIT] = audio_local_id_r;
      sink_regs_pkg::REMOTE_MESSAGE_BYTE_OFS:
        rd_nxt[7:0] = remote_message_byte_r;
      sink_regs_pkg::SINK_SERVICE_REQUEST_OFS:
        rd_nxt = service_view;
      sink_regs_pkg::VIDEO_NOT_ACCEPTED_OFS:
        rd_nxt[sink_regs_pkg::FLAG_BIT] = video_not_accepted_r;
      sink_regs_pkg::AUDIO_NOT_ACCEPTED_OFS:
        rd_nxt[sink_regs_pkg::FLAG_BIT] = audio_not_accepted_r;
      default:
        rd_nxt = 32'h0000_0000;
    endcase
  end

  // sampled in setup so access phase sees flop data; status may age a cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
      prdata_r <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_r <= rd_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync generator
  hsync_pulse_gen u_hsync
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .line_end  (line_end),
    .porch_len (horiz_sync_timing_r[sink_regs_pkg::FRONT_PORCH_MSB:
                                    sink_regs_pkg::FRONT_PORCH_LSB]), // RULE_02
    .pulse_len (horiz_sync_timing_r[sink_regs_pkg::PULSE_WIDTH_MSB:
                                    sink_regs_pkg::PULSE_WIDTH_LSB]), // RULE_03
    .hsync     (vid_hsync), // RULE_01
    .busy      (hsync_busy)
  );

endmodule

// ### sim/sink_timing_and_link_status_regs_assertions.sv
// checker for the sink timing and link status register group
`timescale 1ns/1ns
module sink_regs_checker
(
  input logic        core_clk,
  input logic        rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        line_end,
  input logic        vid_hsync,
  input logic        hsync_busy,
  input logic        remote_pending_clr,
  input logic        remote_pending,
  input logic        down_reply_ready,
  input logic        video_local_id_present,
  input logic [7:0]  remote_message_byte
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  wire wr  = psel && penable && pwrite;
  wire svc = wr && paddr == sink_regs_pkg::SINK_SERVICE_REQUEST_OFS;
  ////////////////////////////////////////////////////////////////////////////
  ready_high_a: assert property (pready) else $error("ready dropped");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access");
  unmapped_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 0)
    else $error("unmapped read not zero");
  pend_set_a: assert property (svc && pwdata[0] |=> remote_pending)
    else $error("pending not set");
  zero_keep_a: assert property (svc && !pwdata[0] && !remote_pending_clr |=> $stable(remote_pending))
    else $error("zero write changed pending");
  reply_set_a: assert property (svc && pwdata[4] |=> down_reply_ready)
    else $error("reply flag not set");
  byte_load_a: assert property (wr && paddr == sink_regs_pkg::REMOTE_MESSAGE_BYTE_OFS
    |=> remote_message_byte == $past(pwdata[7:0])) else $error("remote byte wrong");
  vid_id_a: assert property (wr && paddr == sink_regs_pkg::VIDEO_LOCAL_ID_PRESENT_OFS
    |=> video_local_id_present == $past(pwdata[0])) else $error("video id bit wrong");
  pulse_busy_a: assert property (vid_hsync |-> hsync_busy) else $error("pulse while idle");
  pulse_end_a: assert property ($fell(vid_hsync) |-> !hsync_busy)
    else $error("busy after pulse");
  busy_cause_a: assert property ($rose(hsync_busy) |-> $past(line_end))
    else $error("busy without line end");
  cover property (svc && pwdata[0]);
  cover property ($rose(vid_hsync));
  cover property (pslverr);
endmodule
// every checker input watches the design port of the same name
bind sink_timing_and_link_status_regs sink_regs_checker u_sink_regs_checker
(
  .core_clk               (core_clk),
  .rst                    (rst),
  .psel                   (psel),
  .penable                (penable),
  .pwrite                 (pwrite),
  .paddr                  (paddr),
  .pwdata                 (pwdata),
  .prdata                 (prdata),
  .pready                 (pready),
  .pslverr                (pslverr),
  .line_end               (line_end),
  .vid_hsync              (vid_hsync),
  .hsync_busy             (hsync_busy),
  .remote_pending_clr     (remote_pending_clr),
  .remote_pending         (remote_pending),
  .down_reply_ready       (down_reply_ready),
  .video_local_id_present (video_local_id_present),
  .remote_message_byte    (remote_message_byte)
);

// ### sim/link_cfg_reader.sv
// model of the transmitter reading and clearing link status flags
`timescale 1ns/1ns
module link_cfg_reader
(
  input  logic core_clk,
  input  logic rst,
  input  logic hold,
  input  logic slow,
  input  logic vendor_set,
  input  logic remote_pending,
  input  logic down_reply_ready,
  output logic remote_pending_clr = 1'b0,
  output logic down_reply_clr = 1'b0,
  output logic vendor_local_request = 1'b0
);
  logic [3:0] dly_r = 4'h0;
  // hold lets the host see flags before the far end consumes them
  always @(posedge core_clk)
  begin
    remote_pending_clr <= 1'b0;
    down_reply_clr <= 1'b0;
    vendor_local_request <= vendor_set;
    if (rst)
      dly_r <= 4'h0;
    else if (!hold && (remote_pending || down_reply_ready))
    begin
      dly_r <= dly_r + 4'h1;
      if (dly_r >= (slow ? 4'h7 : 4'h0))
      begin
        remote_pending_clr <= remote_pending;
        down_reply_clr <= down_reply_ready;
        dly_r <= 4'h0;
      end
    end
  end
endmodule

// ### sim/sink_timing_and_link_status_regs_test.sv
// self-checking bench for the sink timing and link status register group
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t got %h exp %h", $time, (g), (e)); end end
module sink_timing_and_link_status_regs_test;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, line_end = 0;
  logic hold = 1, slow = 0, vendor_set = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, i2c_prescale;
  logic pready, pslverr, vid_hsync, hsync_busy, remote_pending_clr, down_reply_clr;
  logic vendor_local_request, video_local_id_present, audio_local_id_present;
  logic video_not_accepted, audio_not_accepted, remote_pending, down_reply_ready;
  logic [7:0] remote_message_byte;
  logic [32:0] q[$];
  logic [15:0] r = 16'hd987;
  logic [31:0] d;
  logic [11:0] ofs [4] = '{sink_regs_pkg::VIDEO_LOCAL_ID_PRESENT_OFS,
    sink_regs_pkg::AUDIO_LOCAL_ID_PRESENT_OFS, sink_regs_pkg::VIDEO_NOT_ACCEPTED_OFS,
    sink_regs_pkg::AUDIO_NOT_ACCEPTED_OFS};
  int mismatches = 0, compares = 0, cyc = 0, n, w;
  wire [3:0] outs = {video_local_id_present, audio_local_id_present,
    video_not_accepted, audio_not_accepted};
  sink_timing_and_link_status_regs u_sink_timing_and_link_status_regs
  (
    .core_clk               (core_clk),
    .rst                    (rst),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .line_end               (line_end),
    .vid_hsync              (vid_hsync),
    .hsync_busy             (hsync_busy),
    .i2c_prescale           (i2c_prescale),
    .remote_pending_clr     (remote_pending_clr),
    .down_reply_clr         (down_reply_clr),
    .vendor_local_request   (vendor_local_request),
    .video_local_id_present (video_local_id_present),
    .audio_local_id_present (audio_local_id_present),
    .remote_message_byte    (remote_message_byte),
    .remote_pending         (remote_pending),
    .down_reply_ready       (down_reply_ready),
    .video_not_accepted     (video_not_accepted),
    .audio_not_accepted     (audio_not_accepted)
  );
  link_cfg_reader u_link_cfg_reader
  (
    .core_clk             (core_clk),
    .rst                  (rst),
    .hold                 (hold),
    .slow                 (slow),
    .vendor_set           (vendor_set),
    .remote_pending       (remote_pending),
    .down_reply_ready     (down_reply_ready),
    .remote_pending_clr   (remote_pending_clr),
    .down_reply_clr       (down_reply_clr),
    .vendor_local_request (vendor_local_request)
  );
  always #2 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task apb(logic wr, logic [11:0] a, logic [31:0] dat);
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= dat;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
    #1;
  endtask
  task rd(logic [11:0] a, logic [32:0] e);
    q.push_back(e);
    apb(0, a, 0);
  endtask
  task hs(logic [7:0] p, logic [7:0] wd);
    apb(1, sink_regs_pkg::HORIZ_SYNC_TIMING_OFS, {16'h0, p, wd});
    @(posedge core_clk) line_end <= 1;
    @(posedge core_clk) line_end <= 0;
    #1 n = 0;
    while (vid_hsync !== 1'b1 && n < 300) begin @(posedge core_clk); #1 n++; end
    `CHK(n, {24'h0, p})
    w = 0;
    while (vid_hsync === 1'b1 && w < 300) begin @(posedge core_clk); #1 w++; end
    `CHK(w, {24'h0, wd})
    `CHK(hsync_busy, 1'b0)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // read results matched in issue order; timeout folds into the verdict
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 8000) begin mismatches++; results; end
    else if (psel && penable && pready && !pwrite)
      `CHK({pslverr, prdata}, q.pop_front())
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 0;
    rd(sink_regs_pkg::HORIZ_SYNC_TIMING_OFS, 33'h0f0f);
    apb(1, sink_regs_pkg::FAST_I2C_CLOCK_PRESCALE_OFS, 32'h017d_783f);
    `CHK(i2c_prescale, 32'h017d_783f)
    apb(1, 12'h0a0, 32'hffff_ffff);
    rd(12'h0a0, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      r = lfsr(r); d = {r, ~r};
      apb(1, ofs[i], d);
      `CHK(outs[3 - i], d[0])
      rd(ofs[i], {32'h0, d[0]});
    end
    r = lfsr(r);
    apb(1, sink_regs_pkg::REMOTE_MESSAGE_BYTE_OFS, {r, r});
    `CHK(remote_message_byte, r[7:0])
    rd(sink_regs_pkg::REMOTE_MESSAGE_BYTE_OFS, {25'h0, r[7:0]});
    $display("register map test done");
    apb(1, sink_regs_pkg::SINK_SERVICE_REQUEST_OFS, 32'h13);
    rd(sink_regs_pkg::SINK_SERVICE_REQUEST_OFS, 33'h11);
    @(posedge core_clk) vendor_set <= 1;
    rd(sink_regs_pkg::SINK_SERVICE_REQUEST_OFS, 33'h13);
    apb(1, sink_regs_pkg::SINK_SERVICE_REQUEST_OFS, 32'h0);
    rd(sink_regs_pkg::SINK_SERVICE_REQUEST_OFS, 33'h13);
    @(posedge core_clk) begin hold <= 0; slow <= 1; end
    n = 0;
    while ((remote_pending || down_reply_ready) && n < 50) begin @(posedge core_clk); n++; end
    rd(sink_regs_pkg::SINK_SERVICE_REQUEST_OFS, 33'h02);
    $display("service request test done");
    hs(8'h03, 8'h05);
    hs(8'h00, 8'h01);
    r = lfsr(r);
    hs({5'h0, r[2:0]}, {4'h0, r[6:3]} | 8'h01);
    hs(8'hff, 8'hff);
    // zero width: porch runs, no pulse may appear
    apb(1, sink_regs_pkg::HORIZ_SYNC_TIMING_OFS, 32'h0000_0200);
    @(posedge core_clk) line_end <= 1;
    @(posedge core_clk) line_end <= 0;
    w = 0;
    repeat (4) begin @(posedge core_clk); #1 if (vid_hsync !== 1'b0) w++; end
    `CHK(w, 0)
    `CHK(hsync_busy, 1'b0)
    $display("sync pulse test done");
    // second reset in mid-run brings the timing back to its default
    @(posedge core_clk) rst <= 1;
    repeat (2) @(posedge core_clk);
    rst <= 0;
    rd(sink_regs_pkg::HORIZ_SYNC_TIMING_OFS, 33'h0f0f);
    rd(sink_regs_pkg::SINK_SERVICE_REQUEST_OFS, 33'h02);
    `CHK(video_local_id_present, 1'b0)
    $display("reset test done");
    results;
  end
endmodule
